// ### clk_source_model.sv
/*
  Far-side clock source for the ripple timer: a square wave on
  clock_input while run is high. Assumes it shares sys_clk with the bench.
*/
`timescale 1ns/100ps
module clk_source_model #(
  parameter int HALF = 4  // sys_clk cycles per half period
) (
  input  wire logic sys_clk,
  input  wire logic run,
  output logic      clock_input
);
  int cnt;  // Cycles spent in the present phase

  initial clock_input = 1'b1;
  initial cnt = 0;

  // Idles high so a stop never makes a stray counting fall
  always @(negedge sys_clk)
  begin
    if (run || !clock_input)
    begin
      if (cnt == HALF - 1)
      begin
        cnt <= 0;
        clock_input <= ~clock_input;
      end
      else
        cnt <= cnt + 1;
    end
    else
      cnt <= 0;
  end
endmodule : clk_source_model

// ### pin_sync.sv
/*
  Two-flop synchroniser for a bundle of asynchronous pins.
  Assumes its reset is already synchronous to clk; the first flop is
  read only by the second.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned WIDTH = 1  // Bits in the bundle
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // First stage, may go metastable

  // Two flops in series, cleared to a constant on reset
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync

// ### ripple_timer.sv
/*
  Programmable 24-stage ripple timer core with stage select, set/reset,
  count hold, oscillator stop, monostable output and parallel test mode.
  Assumes sys_clk runs far faster than clock_input so every falling
  edge of clock_input is seen; all pins are asynchronous to sys_clk.
*/
//
// Behaviour
// - Select code picks stage 9-24 or 1-16
// - Free-run output divides clock by 2^n
// - Both drives carry undivided clock copy
// - Test mode counts three sections in parallel
// - 255 test edges leave all ones
// - Next normal edge ripples all ones to zero
// - Set rising edge drives output high
// - Count hold freezes counter and output outside test mode, except monostable timeout
// - First fall after set drops output
// - Reset high clears; low lets counting run
// - Monostable output rises on edge 2^n/2
// - Monostable pulses recur every 2^n periods
// - Oscillator stays stopped while reset high
// - Output low 2^n/2 periods after reset
// - Power-up output value not assumed
// - Reset rising edge drives output low
// - Set forces high, clears, counts second fall
// - Reset forces low, clears, stops oscillator
// - Monostable off means output follows stage
// - Skip, set and reset high enter test
`timescale 1ns/100ps
module ripple_timer #(
  parameter int unsigned PULSE_W = ripple_timer_pkg::PULSE_W  // Pulse counter width
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic               clock_input,
  input  wire logic               set_in,
  input  wire logic               reset_in,
  input  wire logic               skip_low_stages,
  input  wire logic [3:0]         stage_select,
  input  wire logic               count_hold,
  input  wire logic               oscillator_stop,
  input  wire logic               pulse_shaper_en,
  input  wire logic [PULSE_W-1:0] pulse_len,
  output logic                    timer_output,
  output logic                    osc_drive_a,
  output logic                    osc_drive_b,
  output logic                    test_active
);

  // Stage number minus one for the given select inputs
  function automatic logic [4:0] sel_idx(input logic skip, input logic [3:0] code);
    sel_idx = skip ? {1'b0, code} : 5'({1'b0, code} + ripple_timer_pkg::LOW_SKIP);
  endfunction : sel_idx

  logic [1:0]                 rst_sq;   // Reset release synchroniser
  logic                       rst_s_b;  // Synchronous reset copy
  ripple_timer_pkg::pin_in_s  pin_raw;  // Pins as they arrive
  ripple_timer_pkg::pin_in_s  pin;      // Pins after two flops
  ripple_timer_pkg::state_s   st_q;     // Registered state
  ripple_timer_pkg::state_s   st_d;     // Next state
  logic [4:0]                 idx;      // Selected stage index
  logic                       fall;     // Falling edge of clock_input
  logic                       test_now; // Test mode condition
  logic                       hold;     // Counting frozen
  logic [PULSE_W-1:0]         plen;     // Pulse length, at least one

  // Release reset through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sq <= 2'h0;
    else
      rst_sq <= {rst_sq[0], 1'b1};
  end
  assign rst_s_b = rst_sq[1];

  // Pack pins for the synchroniser
  assign pin_raw = '{clock_input, set_in, reset_in, skip_low_stages, stage_select,
                     count_hold, oscillator_stop, pulse_shaper_en};

  pin_sync #(
    .WIDTH    ($bits(ripple_timer_pkg::pin_in_s))
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_s_b),
    .async_in (pin_raw),
    .sync_out (pin)
  );

  // Decoded conditions shared by next-state logic and checks
  assign idx      = sel_idx(pin.skip_low_stages, pin.stage_select);
  assign fall     = st_q.clk_prev & ~pin.clock_input;
  assign test_now = pin.skip_low_stages & pin.set_in & pin.reset_in;
  // Oscillator stop also freezes the count with an external clock
  assign hold     = pin.count_hold | pin.oscillator_stop;
  assign plen     = (pulse_len == '0) ? PULSE_W'(ripple_timer_pkg::PULSE_MIN) : pulse_len;

  // Next state; set and reset act as levels, so their rising edges are covered
  always_comb
  begin
    st_d          = st_q;
    st_d.clk_prev = pin.clock_input;
    st_d.test     = test_now;
    // Set or reset hold the oscillator still for standby
    st_d.osc_run  = ~pin.set_in & ~pin.reset_in & ~pin.oscillator_stop;
    // Undivided copy; stopped drive parks a low, b high
    st_d.drive_a  = st_d.osc_run & pin.clock_input;
    st_d.drive_b  = ~st_d.osc_run | pin.clock_input;
    if (test_now)
    begin
      // Sections clock in parallel, each wraps on its own
      if (fall)
      begin
        for (int s = 0; s < ripple_timer_pkg::SECTIONS; s++)
          st_d.stages[s*8 +: 8] = st_q.stages[s*8 +: 8] + 8'h01;
      end
      st_d.out       = st_d.stages[idx];
      st_d.pend      = 1'b0;
      st_d.pulse_cnt = '0;
    end
    else if (pin.reset_in)
    begin
      // Reset wins over set outside test mode
      st_d.stages    = ripple_timer_pkg::STAGES_RST;
      st_d.out       = 1'b0;
      st_d.pend      = 1'b0;
      st_d.pulse_cnt = '0;
    end
    else if (pin.set_in)
    begin
      st_d.stages    = ripple_timer_pkg::STAGES_RST;
      st_d.out       = 1'b1;
      st_d.pend      = 1'b1;
      st_d.pulse_cnt = '0;
    end
    else
    begin
      // Monostable timeout runs on the system clock
      if (pin.pulse_shaper_en && st_q.pulse_cnt != '0)
      begin
        st_d.pulse_cnt = st_q.pulse_cnt - PULSE_W'(1);
        if (st_q.pulse_cnt == PULSE_W'(1))
          st_d.out = 1'b0;
      end
      if (fall && !hold)
      begin
        if (st_q.pend)
        begin
          // First fall after set only drops the output
          st_d.out       = 1'b0;
          st_d.pend      = 1'b0;
          st_d.pulse_cnt = '0;
        end
        else
        begin
          // Ripple carry, all ones wraps to zero
          st_d.stages = st_q.stages + 24'h000001;
          if (!pin.pulse_shaper_en)
            st_d.out = st_d.stages[idx];
          else if (st_d.stages[idx] && !st_q.stages[idx])
          begin
            // Rising stage fires a fresh pulse
            st_d.out       = 1'b1;
            st_d.pulse_cnt = plen;
          end
        end
      end
    end
  end

  // One register for all state; out resets low, power-up value is not relied on
  always_ff @(posedge sys_clk or negedge rst_s_b)
  begin
    if (!rst_s_b)
    begin
      st_q           <= '0;
      st_q.pulse_cnt <= ripple_timer_pkg::PULSE_RST;
    end
    else
      st_q <= st_d;
  end

  // Outputs straight from state flops
  assign timer_output = st_q.out;
  assign osc_drive_a  = st_q.drive_a;
  assign osc_drive_b  = st_q.drive_b;
  assign test_active  = st_q.test;

  // Counting step outside set, reset and test
  logic run_step;  // Helper for checks
  assign run_step = fall & ~hold & ~pin.set_in & ~pin.reset_in & ~test_now;

  property p_reset_clear;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (pin.reset_in && !test_now) |=> (!timer_output && st_q.stages == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset did not clear output and stages");

  property p_set_force;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (pin.set_in && !pin.reset_in) |=> (timer_output && st_q.stages == '0 && st_q.pend);
  endproperty
  a_set_force: assert property (p_set_force)
    else $error("set did not force output high");

  property p_hold_freeze;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (hold && !pin.set_in && !pin.reset_in && !test_now) |=> $stable(st_q.stages);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("counter moved while held");

  property p_drive_copy;
    @(posedge sys_clk) disable iff (!rst_s_b)
    st_d.osc_run |=> (osc_drive_a == $past(pin.clock_input) && osc_drive_b == osc_drive_a);
  endproperty
  a_drive_copy: assert property (p_drive_copy)
    else $error("drive outputs do not copy the clock");

  property p_osc_stop;
    @(posedge sys_clk) disable iff (!rst_s_b)
    pin.reset_in |=> (!osc_drive_a && osc_drive_b && !st_q.osc_run);
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator ran during reset");

  property p_test_parallel;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (test_now && fall) |=> (st_q.stages[7:0] == 8'($past(st_q.stages[7:0]) + 8'h01)
                            && st_q.stages[15:8] == 8'($past(st_q.stages[15:8]) + 8'h01)
                            && st_q.stages[23:16] == 8'($past(st_q.stages[23:16]) + 8'h01));
  endproperty
  a_test_parallel: assert property (p_test_parallel)
    else $error("test sections did not step together");

  property p_select_follow;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (run_step && !st_q.pend && !pin.pulse_shaper_en) |=>
      (timer_output == st_q.stages[$past(idx)]);
  endproperty
  a_select_follow: assert property (p_select_follow)
    else $error("output does not follow selected stage");

  property p_ripple_zero;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (run_step && !st_q.pend && st_q.stages == 24'hffffff) |=> (st_q.stages == '0);
  endproperty
  a_ripple_zero: assert property (p_ripple_zero)
    else $error("all ones did not ripple to zero");

  property p_first_fall;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (run_step && st_q.pend) |=> (!timer_output && !st_q.pend && st_q.stages == '0);
  endproperty
  a_first_fall: assert property (p_first_fall)
    else $error("first fall after set did not drop output");

  property p_pulse_start;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (run_step && !st_q.pend && pin.pulse_shaper_en && st_d.stages[idx] && !st_q.stages[idx])
      |=> (timer_output && st_q.pulse_cnt == $past(plen));
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("monostable pulse did not load its length");

  // Last cycle of a pulse drops the output unless a fresh rise reloads it
  property p_pulse_end;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (pin.pulse_shaper_en && st_q.pulse_cnt == PULSE_W'(1) && !pin.set_in && !pin.reset_in
      && !test_now && !(st_d.stages[idx] && !st_q.stages[idx])) |=> !timer_output;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("monostable pulse did not end");

  // Test mode output tracks the selected section bit
  property p_test_out;
    @(posedge sys_clk) disable iff (!rst_s_b)
    test_now |=> (timer_output == st_q.stages[$past(idx)]);
  endproperty
  a_test_out: assert property (p_test_out)
    else $error("test output does not follow stage");

  // Idle monostable keeps its output between pulses
  property p_mono_idle;
    @(posedge sys_clk) disable iff (!rst_s_b)
    (pin.pulse_shaper_en && st_q.pulse_cnt == '0 && !run_step && !pin.set_in
      && !pin.reset_in && !test_now) |=> $stable(timer_output);
  endproperty
  a_mono_idle: assert property (p_mono_idle)
    else $error("monostable output moved while idle");

  c_test_full: cover property (@(posedge sys_clk) disable iff (!rst_s_b)
    test_now && st_q.stages == 24'hffffff);
  c_mono_pulse: cover property (@(posedge sys_clk) disable iff (!rst_s_b)
    pin.pulse_shaper_en && $fell(timer_output));
  c_set_count: cover property (@(posedge sys_clk) disable iff (!rst_s_b)
    run_step && st_q.pend ##[1:200] run_step && !st_q.pend);
  c_wrap: cover property (@(posedge sys_clk) disable iff (!rst_s_b)
    run_step && st_q.stages == 24'hffffff);
  c_hold_fall: cover property (@(posedge sys_clk) disable iff (!rst_s_b)
    fall && pin.count_hold && !pin.set_in && !pin.reset_in);

endmodule : ripple_timer

// ### ripple_timer_pkg.sv
/*
  Shared constants and carriers for the programmable ripple timer.
  Assumes a single system clock domain; every pin but pulse_len is resynchronised
  before the timer core reads it.
*/
package ripple_timer_pkg;

  // Counter geometry
  localparam int unsigned STAGES      = 24;  // Stages in series
  localparam int unsigned SECT_W      = 8;   // Stages per test section
  localparam int unsigned SECTIONS    = 3;   // Sections in test mode
  localparam int unsigned SEL_W       = 4;   // Select code width
  localparam int unsigned IDX_W       = 5;   // Stage index width
  localparam logic [4:0]  LOW_SKIP    = 5'h08; // Stages skipped by default
  localparam int unsigned PULSE_W     = 16;  // Monostable counter width

  // Reset values and minimum pulse length
  localparam logic [23:0] STAGES_RST  = 24'h000000;
  localparam logic [15:0] PULSE_RST   = 16'h0000;
  localparam logic [15:0] PULSE_MIN   = 16'h0001; // Zero length is stretched

  // Pin group, one field per documented input
  typedef struct packed {
    logic       clock_input;      // Counting clock, falling edge active
    logic       set_in;           // Force output high, clear stages
    logic       reset_in;         // Force output low, clear stages
    logic       skip_low_stages;  // Low bypasses first eight stages, high selects from stage 1
    logic [3:0] stage_select;     // Stage select code
    logic       count_hold;       // Freeze counter
    logic       oscillator_stop;  // Stop oscillator drive
    logic       pulse_shaper_en;  // Monostable in use
  } pin_in_s;

  // Whole core state
  typedef struct packed {
    logic [23:0] stages;     // Counter flip-flops, bit 0 is stage 1
    logic        out;        // Output conditioning latch
    logic        pend;       // Set released, waiting for first fall
    logic        clk_prev;   // Last sampled clock level
    logic        osc_run;    // Oscillator drive enabled
    logic        drive_a;    // Buffered clock copy, idles low
    logic        drive_b;    // Buffered clock copy, idles high
    logic        test;       // Parallel section mode active
    logic [15:0] pulse_cnt;  // Monostable cycles left
  } state_s;

endpackage : ripple_timer_pkg

// ### tb.sv
/*
  Self-checking bench for the ripple timer, pins driven on falling sys_clk.
  Assumes the design answers three sys_clk edges after a pin change.
*/
`timescale 1ns/100ps
module tb;
  logic sys_clk, rst_b, run, set_in, reset_in, skip, hold, ostop, mono_en;
  logic [3:0] sel;
  logic [15:0] plen;
  logic clock_input, tout, drv_a, drv_b, tst;
  int errors, num_checks, cyc;

  clk_source_model src (.sys_clk(sys_clk), .run(run), .clock_input(clock_input));

  ripple_timer dut (.sys_clk(sys_clk), .rst_b(rst_b), .clock_input(clock_input),
    .set_in(set_in), .reset_in(reset_in), .skip_low_stages(skip), .stage_select(sel),
    .count_hold(hold), .oscillator_stop(ostop), .pulse_shaper_en(mono_en),
    .pulse_len(plen), .timer_output(tout), .osc_drive_a(drv_a),
    .osc_drive_b(drv_b), .test_active(tst));

  // Free clock, 5 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Cut a hang short; whole run is near 6600 cycles
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      summarize();
    end
  end

  task automatic chk(string what, logic exp, logic got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  // n counting falls, then let the source park high
  task automatic pulses(int n);
    if (n > 0)
    begin
      run <= 1'b1;
      repeat (n) @(negedge clock_input);
      @(negedge sys_clk);
      run <= 1'b0;
    end
  endtask : pulses

  // Reset pulse; output and drives parked while it is high
  task automatic do_reset();
    reset_in <= 1'b1;
    tick(4);
    chk("reset out", 1'b0, tout);
    chk("reset drv_a", 1'b0, drv_a);
    chk("reset drv_b", 1'b1, drv_b);
    reset_in <= 1'b0;
    tick(4);
  endtask : do_reset

  // One selection: low until 2^(n-1) falls, high, then low again
  task automatic t_select(logic s, logic [3:0] code, int n);
    int half;
    half = 1 << (n - 1);
    skip <= s;
    sel <= code;
    do_reset();
    pulses(half - 1);
    tick(8);
    chk("sel low", 1'b0, tout);
    pulses(1);
    tick(8);
    chk("sel high", 1'b1, tout);
    pulses(half);
    tick(8);
    chk("sel again low", 1'b0, tout);
  endtask : t_select

  // Set forces high; first fall drops, second fall counts
  task automatic t_set();
    skip <= 1'b1;
    sel <= 4'h0;
    do_reset();
    set_in <= 1'b1;
    tick(4);
    chk("set out", 1'b1, tout);
    set_in <= 1'b0;
    tick(4);
    hold <= 1'b1;
    pulses(3);
    tick(8);
    chk("hold out", 1'b1, tout);
    hold <= 1'b0;
    tick(4);
    pulses(1);
    tick(8);
    chk("first fall", 1'b0, tout);
    pulses(1);
    tick(8);
    chk("second fall", 1'b1, tout);
  endtask : t_set

  // Drives copy the clock; stop parks them
  task automatic t_drive();
    run <= 1'b1;
    @(negedge clock_input);
    tick(3);
    chk("drv_a low", 1'b0, drv_a);
    chk("drv_b low", 1'b0, drv_b);
    tick(4);
    chk("drv_a high", 1'b1, drv_a);
    chk("drv_b high", 1'b1, drv_b);
    ostop <= 1'b1;
    tick(5);
    chk("stop drv_a", 1'b0, drv_a);
    chk("stop drv_b", 1'b1, drv_b);
    run <= 1'b0;
    ostop <= 1'b0;
    tick(12);
  endtask : t_drive

  // Parallel sections fill in 255 falls, one series fall clears
  task automatic t_test();
    sel <= 4'h0;
    skip <= 1'b1;
    reset_in <= 1'b1;
    tick(4);
    set_in <= 1'b1;
    tick(4);
    chk("test entry", 1'b1, tst);
    pulses(255);
    tick(8);
    chk("all ones", 1'b1, tout);
    set_in <= 1'b0;
    reset_in <= 1'b0;
    skip <= 1'b0;
    tick(4);
    chk("test exit", 1'b0, tst);
    chk("still ones", 1'b1, tout);
    pulses(1);
    tick(8);
    chk("ripple zero", 1'b0, tout);
  endtask : t_test

  // Monostable on stage 2: pulse of plen cycles at fall 2, then every 4
  task automatic t_mono();
    skip <= 1'b1;
    sel <= 4'h1;
    mono_en <= 1'b1;
    plen <= 16'h0005;
    do_reset();
    pulses(2);
    tick(4);
    chk("mono rise", 1'b1, tout);
    tick(6);
    chk("mono end", 1'b0, tout);
    pulses(3);
    tick(8);
    chk("mono wait", 1'b0, tout);
    pulses(1);
    tick(4);
    chk("mono again", 1'b1, tout);
    tick(8);
    mono_en <= 1'b0;
  endtask : t_mono

  initial
  begin
    {rst_b, run, set_in, reset_in, skip, hold, ostop, mono_en} = 8'h00;
    sel = 4'h0;
    plen = 16'h0001;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    tick(6);
    rst_b <= 1'b1;
    tick(4);
    t_select(1'b1, 4'h0, 1);
    t_select(1'b1, 4'h3, 4);
    t_select(1'b0, 4'h0, 9);
    t_set();
    t_drive();
    t_test();
    t_mono();
    summarize();
  end
endmodule : tb
